// File: hw/otpl_map.vh
/*
  Constants for the security-register program and hardware-lock block:
  opcodes, status bit positions, array sizes and program timing.
  Assumes a 50 MHz system clock.
*/
`ifndef OTPL_MAP_VH
`define OTPL_MAP_VH

// Opcodes
`define OTPL_OP_WR_ENABLE   8'h06
`define OTPL_OP_WR_DISABLE  8'h04
`define OTPL_OP_WR_STATUS   8'h01
`define OTPL_OP_SEC_PROG    8'h9B

// Status bit positions
`define OTPL_ST_LOCK_BIT    7
`define OTPL_ST_ERR_BIT     5
`define OTPL_ST_WPP_BIT     4
`define OTPL_ST_PROT_BIT    2
`define OTPL_ST_WEL_BIT     1
`define OTPL_ST_BUSY_BIT    0

// Sizes
`define OTPL_USER_BYTES     64
`define OTPL_SEC_BYTES      128
`define OTPL_BUF_BYTES      256
`define OTPL_ERASED         8'hFF
`define OTPL_FIRST_DATA_IDX 3'h4

// Timing
`define OTPL_CLK_MHZ        50
`define OTPL_PROG_TIME_NS   500000
`define OTPL_PROG_CYCLES    ((`OTPL_PROG_TIME_NS * `OTPL_CLK_MHZ) / 1000)

`endif

// File: hw/otpl_top.v
/*
  Serial flash security-register program command and hardware locking of
  the array-protection setting. Decodes write enable, write disable, write
  status and program-security-register commands from an SPI host.
  Assumes SPI mode 0 or 3 with a serial clock well below CLK_IN / 4, all
  pins asynchronous to CLK_IN, and RESET_IN standing for a power cycle.

*/
`timescale 1ns/100ps
`include "otpl_map.vh"

module otpl_top #(
  parameter        PROG_CYCLES  = `OTPL_PROG_CYCLES,
  parameter [7:0]  FACTORY_SEED = 8'h5A  // Arbitrary value, no meaning
) (
  // Clock and reset
  input  wire        CLK_IN,
  input  wire        RESET_IN,
  // Serial pins
  input  wire        SCK_IN,
  input  wire        CS_N_IN,
  input  wire        SI_IN,
  input  wire        WP_N_IN,
  // Security register read port
  input  wire [6:0]  SEC_RD_ADDR_IN,
  output reg  [7:0]  SEC_RD_DATA_OUT,
  // Status
  output reg  [7:0]  STATUS_OUT,
  output reg         BUSY_OUT,
  output reg         HW_LOCKED_OUT,
  output reg         ARRAY_PROTECT_OUT,
  output reg         OTP_USED_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // One-hot program states
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WRITE = 3'b010;
  localparam [2:0] ST_WAIT  = 3'b100;
  // Wait counter is 24 bits wide, so PROG_CYCLES must not exceed 2**24
  localparam integer PROG_LAST_I = PROG_CYCLES - 1;
  localparam [23:0]  PROG_LAST   = PROG_LAST_I[23:0];

  // Factory half: fixed per device, derived from the seed
  function [7:0] factory_byte;
    input [5:0] idx;
    begin
      factory_byte = FACTORY_SEED ^ {idx[5:0], 2'b01} ^ {2'b00, idx[5:0]};
    end
  endfunction

  // Six-bit pointer step; wraps from 3Fh to 00h at the user-area end
  function [5:0] next_idx;
    input [5:0] idx;
    begin
      next_idx = idx + 6'h01;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg  [2:0]  sck_sync_reg;
  reg  [2:0]  cs_sync_reg;
  reg  [1:0]  si_sync_reg;
  reg  [1:0]  wp_sync_reg;

  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      sck_sync_reg <= 3'h0;
      cs_sync_reg  <= 3'h7;
      si_sync_reg  <= 2'h0;
      wp_sync_reg  <= 2'h3;
    end else begin
      sck_sync_reg <= {sck_sync_reg[1:0], SCK_IN};
      cs_sync_reg  <= {cs_sync_reg[1:0], CS_N_IN};
      si_sync_reg  <= {si_sync_reg[0], SI_IN};
      wp_sync_reg  <= {wp_sync_reg[0], WP_N_IN};
    end
  end

  wire        sck_rise  = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire        cs_active = ~cs_sync_reg[1];
  wire        cs_fall   = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire        cs_rise   = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire        si_bit    = si_sync_reg[1];
  wire        wp_n      = wp_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  reg  [2:0]  state_reg;
  reg  [6:0]  shift_reg;
  reg  [2:0]  bit_cnt_reg;
  reg  [2:0]  byte_cnt_reg;
  reg  [7:0]  opcode_reg;
  reg  [7:0]  wr_status_reg;
  reg  [5:0]  ptr_reg;
  reg  [63:0] valid_reg;
  reg  [5:0]  wr_idx_reg;
  reg  [23:0] timer_reg;
  reg         lock_bit_reg;
  reg         wel_reg;

  // Nonvolatile state: survives RESET_IN, starts blank
  reg         protect_bit_reg;
  reg         used_reg;
  reg  [7:0]  user_mem [0:`OTPL_USER_BYTES-1];
  // Shared buffer; this command only touches the low 64 entries
  reg  [7:0]  buf_mem  [0:`OTPL_BUF_BYTES-1];
  integer     i;

  initial begin
    protect_bit_reg = 1'b0;
    used_reg        = 1'b0;
    for (i = 0; i < `OTPL_USER_BYTES; i = i + 1) begin
      user_mem[i] = `OTPL_ERASED;
    end
  end

  wire        busy      = ~state_reg[0];
  wire        hw_lock   = ~wp_n & lock_bit_reg;
  wire [7:0]  rx_byte   = {shift_reg, si_bit};
  wire        byte_done = sck_rise & cs_active & ~busy & (bit_cnt_reg == 3'h7);
  wire        aligned   = (bit_cnt_reg == 3'h0);
  wire        prog_cmd  = (opcode_reg == `OTPL_OP_SEC_PROG);
  wire        data_byte = byte_done & prog_cmd & (byte_cnt_reg >= `OTPL_FIRST_DATA_IDX);
  wire        prog_ok   = wel_reg & aligned & ~used_reg &
                          (byte_cnt_reg > `OTPL_FIRST_DATA_IDX);

  ////////////////////////////////////////////////////////////////////////////
  // Buffer and user-area writes
  always @(posedge CLK_IN) begin
    if (data_byte) begin
      buf_mem[{2'b00, ptr_reg}] <= rx_byte;
    end
    if (state_reg == ST_WRITE && valid_reg[wr_idx_reg]) begin
      user_mem[wr_idx_reg] <= buf_mem[{2'b00, wr_idx_reg}];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode, status bits and program sequencing
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 7'h00;
      bit_cnt_reg   <= 3'h0;
      byte_cnt_reg  <= 3'h0;
      opcode_reg    <= 8'h00;
      wr_status_reg <= 8'h00;
      ptr_reg       <= 6'h00;
      valid_reg     <= 64'h0000_0000_0000_0000;
      wr_idx_reg    <= 6'h00;
      timer_reg     <= 24'h00_0000;
      lock_bit_reg  <= 1'b0;
      wel_reg       <= 1'b0;
    end else begin
      // A frame begun while busy loses the bits clocked while busy, and a release while busy is ignored
      if (cs_fall) begin
        bit_cnt_reg  <= 3'h0;
        byte_cnt_reg <= 3'h0;
      end else if (sck_rise && cs_active && !busy) begin
        shift_reg   <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7 && byte_cnt_reg != 3'h7) begin
          byte_cnt_reg <= byte_cnt_reg + 3'h1;
        end
      end

      if (byte_done) begin
        case (byte_cnt_reg)
          3'h0: begin
            opcode_reg <= rx_byte;
            if (rx_byte == `OTPL_OP_SEC_PROG) begin
              valid_reg <= 64'h0000_0000_0000_0000;
            end
          end
          3'h1: begin
            wr_status_reg <= rx_byte;
          end
          3'h3: begin
            ptr_reg <= rx_byte[5:0];
          end
          default: begin
          end
        endcase
      end

      if (data_byte) begin
        valid_reg[ptr_reg] <= 1'b1;
        ptr_reg            <= next_idx(ptr_reg);
      end

      case (state_reg)
        ST_IDLE: begin
          if (cs_rise && byte_cnt_reg != 3'h0) begin
            case (opcode_reg)
              `OTPL_OP_WR_ENABLE: begin
                if (aligned) begin
                  wel_reg <= 1'b1;
                end
              end
              `OTPL_OP_WR_DISABLE: begin
                if (aligned) begin
                  wel_reg <= 1'b0;
                end
              end
              `OTPL_OP_WR_STATUS: begin
                if (aligned && byte_cnt_reg >= 3'h2 && wel_reg && !hw_lock) begin
                  if (!lock_bit_reg || wp_n) begin
                    lock_bit_reg <= wr_status_reg[`OTPL_ST_LOCK_BIT];
                  end
                  protect_bit_reg <= wr_status_reg[`OTPL_ST_PROT_BIT];
                  wel_reg         <= 1'b0;
                end
              end
              `OTPL_OP_SEC_PROG: begin
                if (prog_ok) begin
                  used_reg   <= 1'b1;
                  wr_idx_reg <= 6'h00;
                  state_reg  <= ST_WRITE;
                end else if (wel_reg) begin
                  wel_reg <= 1'b0;
                end
              end
              default: begin
              end
            endcase
          end
        end
        ST_WRITE: begin
          wel_reg    <= 1'b0;
          wr_idx_reg <= next_idx(wr_idx_reg);
          if (wr_idx_reg == 6'h3F) begin
            timer_reg <= 24'h00_0000;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          timer_reg <= timer_reg + 24'h00_0001;
          if (timer_reg >= PROG_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Used flag is set at program start, so a power loss mid-cycle keeps it

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always @(posedge CLK_IN) begin
    if (RESET_IN) begin
      SEC_RD_DATA_OUT   <= 8'h00;
      STATUS_OUT        <= 8'h00;
      BUSY_OUT          <= 1'b0;
      HW_LOCKED_OUT     <= 1'b0;
      ARRAY_PROTECT_OUT <= 1'b0;
      OTP_USED_OUT      <= 1'b0;
    end else begin
      if (SEC_RD_ADDR_IN[6]) begin
        SEC_RD_DATA_OUT <= factory_byte(SEC_RD_ADDR_IN[5:0]);
      end else begin
        SEC_RD_DATA_OUT <= user_mem[SEC_RD_ADDR_IN[5:0]];
      end
      STATUS_OUT        <= {lock_bit_reg, 1'b0, 1'b0, wp_n,
                            1'b0, protect_bit_reg, wel_reg, busy};
      BUSY_OUT          <= busy;
      HW_LOCKED_OUT     <= hw_lock;
      ARRAY_PROTECT_OUT <= protect_bit_reg;
      OTP_USED_OUT      <= used_reg;
    end
  end

endmodule // otpl_top

// File: dv/otpl_host.sv
/* Serial host model: mode 0 frames, MSB first, 160 ns bit period.
   Assumes the 50 MHz bench clock drives clk_in. */
`timescale 1ns/100ps
module otpl_host (
  input  wire clk_in,
  output reg  sck_out,
  output reg  cs_n_out,
  output reg  si_out
);
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
  end
  // Sends nbits from the top of d; the released data line shows the inverted last bit
  task frame(input integer nbits, input [63:0] d);
    integer i;
    begin
      @(posedge clk_in) cs_n_out <= 1'b0;
      for (i = 0; i < nbits; i = i + 1) begin
        si_out <= d[63-i];
        repeat (4) @(posedge clk_in);
        sck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        sck_out <= 1'b0;
      end
      repeat (4) @(posedge clk_in);
      cs_n_out <= 1'b1;
      si_out   <= ~si_out;
      repeat (8) @(posedge clk_in);
    end
  endtask
endmodule // otpl_host

// File: dv/otpl_checker.sv
/* Port assertions for the security program and lock block.
   Assumes one CLK_IN domain; bound to otpl_top below. */
`timescale 1ns/100ps
module otpl_checker (
  input wire       CLK_IN,
  input wire       RESET_IN,
  input wire       CS_N_IN,
  input wire [7:0] STATUS_OUT,
  input wire       BUSY_OUT,
  input wire       HW_LOCKED_OUT,
  input wire       ARRAY_PROTECT_OUT,
  input wire       OTP_USED_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);
  a_lock_needs_both: assert property (HW_LOCKED_OUT == (STATUS_OUT[7] && !STATUS_OUT[4]))
    else $error("lock flag disagrees with lock bit and pin");
  a_locked_bits_frozen: assert property (HW_LOCKED_OUT && $past(HW_LOCKED_OUT)
    |-> $stable(STATUS_OUT[7]) && $stable(ARRAY_PROTECT_OUT))
    else $error("locked bits changed");
  a_lock_clear_free: assert property ($fell(STATUS_OUT[7]) |-> STATUS_OUT[4])
    else $error("lock bit cleared with pin asserted");
  a_busy_in_status: assert property (BUSY_OUT == STATUS_OUT[0])
    else $error("busy flag mismatch");
  a_protect_shown: assert property (ARRAY_PROTECT_OUT == STATUS_OUT[2])
    else $error("protect output mismatch");
  a_used_sticky: assert property ($past(OTP_USED_OUT) |-> OTP_USED_OUT)
    else $error("used flag dropped");
  a_prog_after_cs: assert property ($rose(BUSY_OUT) |-> CS_N_IN ##0 BUSY_OUT[*8])
    else $error("program not started by release");
  a_wel_gone_end: assert property ($fell(BUSY_OUT) |-> !STATUS_OUT[1])
    else $error("write enable still set at end");
  a_used_at_start: assert property ($rose(BUSY_OUT) |-> ##[0:2] OTP_USED_OUT)
    else $error("used flag not set at start");
  a_reserved_zero: assert property (STATUS_OUT[6] == 1'b0 && STATUS_OUT[3] == 1'b0)
    else $error("reserved status bit set");
endmodule // otpl_checker
bind otpl_top otpl_checker i_otpl_checker (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
  .CS_N_IN(CS_N_IN), .STATUS_OUT(STATUS_OUT), .BUSY_OUT(BUSY_OUT),
  .HW_LOCKED_OUT(HW_LOCKED_OUT), .ARRAY_PROTECT_OUT(ARRAY_PROTECT_OUT),
  .OTP_USED_OUT(OTP_USED_OUT));

// File: dv/testbench.sv
/* Self-checking bench for otpl_top driven by the host model.
   Assumes otpl_map.vh on the include path. */
`timescale 1ns/100ps
`include "otpl_map.vh"
module testbench;
  reg        clk_in   = 1'b0;
  reg        reset_in = 1'b1;
  reg        wp_n     = 1'b1;
  reg  [6:0] rd_addr  = 7'h00;
  wire       sck, cs_n, si, busy, hw_lock, prot, used;
  wire [7:0] rd_data, status;
  integer    miscompares = 0;
  integer    compares    = 0;
  integer    n;
  always #10 clk_in = ~clk_in;
  otpl_host i_otpl_host (.clk_in(clk_in), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  otpl_top #(.PROG_CYCLES(20)) i_otpl_top (.CLK_IN(clk_in), .RESET_IN(reset_in),
    .SCK_IN(sck), .CS_N_IN(cs_n), .SI_IN(si), .WP_N_IN(wp_n), .SEC_RD_ADDR_IN(rd_addr),
    .SEC_RD_DATA_OUT(rd_data), .STATUS_OUT(status), .BUSY_OUT(busy),
    .HW_LOCKED_OUT(hw_lock), .ARRAY_PROTECT_OUT(prot), .OTP_USED_OUT(used));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task sec(input [6:0] a, input [7:0] exp);
    begin
      @(posedge clk_in) rd_addr <= a;
      repeat (2) @(posedge clk_in);
      #1 chk(rd_data, exp);
    end
  endtask
  task wren;
    i_otpl_host.frame(8, {`OTPL_OP_WR_ENABLE, 56'h0});
  endtask
  task wrsr(input [7:0] v);
    i_otpl_host.frame(16, {`OTPL_OP_WR_STATUS, v, 48'h0});
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_disable;
    begin
      wren;
      i_otpl_host.frame(8, {`OTPL_OP_WR_DISABLE, 56'h0});
      #1 chk(status, 8'h10);
      i_otpl_host.frame(12, {`OTPL_OP_WR_ENABLE, 56'h0});
      #1 chk(status, 8'h10);
    end
  endtask
  task t_abort;
    begin
      wren;
      #1 chk(status, 8'h12);
      i_otpl_host.frame(24, {`OTPL_OP_SEC_PROG, 56'h0});
      #1 chk(status, 8'h10);
      chk(used, 1'b0);
    end
  endtask
  task t_prog;
    begin
      wren;
      i_otpl_host.frame(56, {`OTPL_OP_SEC_PROG, 24'hFF_FFFE, 24'hAA_BBCC, 8'h00});
      #1 chk(status & 8'h03, 8'h01);
      chk(used, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 500) begin
        @(posedge clk_in);
        n = n + 1;
      end
      chk(n < 500, 1'b1);
      sec(7'h3E, 8'hAA);
      sec(7'h3F, 8'hBB);
      sec(7'h00, 8'hCC);
      sec(7'h01, 8'hFF);
      sec(7'h3D, 8'hFF);
    end
  endtask
  task t_again;
    begin
      wren;
      i_otpl_host.frame(40, {`OTPL_OP_SEC_PROG, 24'h00_0000, 8'h11, 24'h0});
      #1 chk(status, 8'h10);
      sec(7'h00, 8'hCC);
    end
  endtask
  task t_lock;
    begin
      wren;
      wrsr(8'h84);
      #1 chk(status, 8'h94);
      chk(hw_lock, 1'b0);
      @(posedge clk_in) wp_n <= 1'b0;
      repeat (6) @(posedge clk_in);
      #1 chk(hw_lock, 1'b1);
      wren;
      wrsr(8'h00);
      #1 chk(status & 8'hFD, 8'h84);
      @(posedge clk_in) wp_n <= 1'b1;
      wren;
      wrsr(8'h00);
      #1 chk(status, 8'h10);
      chk(prot, 1'b0);
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    #200_000;
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    t_disable;
    t_abort;
    t_prog;
    t_again;
    t_lock;
    wrap_up;
  end
endmodule // testbench
